// *** shared/nor_host_pkg.sv ***
// constants, timing and state encoding of the parallel nor flash host controller
// What this block does
// - host holds width select steady, never floating
// - reset pulse long enough, then wait recovery
// - host uses only low byte of status
// - host flags a die change on rsp_die_changed_o and reissues nothing
// - write address on later fall, output enable high
// - read: select, output enable low, strobe high
package nor_host_pkg;

	// ************************************************************
	// clock and timer
	// ************************************************************
	localparam int CLK_PERIOD_NS = 20;
	localparam int TMR_W         = 8;

	// ************************************************************
	// bus timing in nanoseconds, least times
	// ************************************************************
	localparam int MIN_RESET_PULSE_TIME_NS = 500;
	localparam int RESET_ABORT_TIME_NS     = 1000;
	localparam int RESET_TO_READ_DELAY_NS  = 200;
	localparam int RESET_TO_WRITE_DELAY_NS = 200;
	localparam int RANDOM_ACCESS_NS        = 120;
	localparam int PAGE_ACCESS_NS          = 40;
	localparam int ADDR_SETUP_NS           = 20;
	localparam int WRITE_PULSE_NS          = 40;
	localparam int DATA_HOLD_NS            = 20;
	localparam int CS_HIGH_NS              = 40;

	// ************************************************************
	// the same times as whole clock cycles, rounded up
	// ************************************************************
	localparam int RST_HOLD_NS = (MIN_RESET_PULSE_TIME_NS > RESET_ABORT_TIME_NS) ?
	                             MIN_RESET_PULSE_TIME_NS : RESET_ABORT_TIME_NS;
	localparam int WAKE_NS     = (RESET_TO_READ_DELAY_NS > RESET_TO_WRITE_DELAY_NS) ?
	                             RESET_TO_READ_DELAY_NS : RESET_TO_WRITE_DELAY_NS;
	localparam logic [TMR_W-1:0] RST_HOLD_CYC = TMR_W'((RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [TMR_W-1:0] WAKE_CYC     = TMR_W'((WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [TMR_W-1:0] ACCESS_CYC   = TMR_W'((RANDOM_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [TMR_W-1:0] PAGE_CYC     = TMR_W'((PAGE_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [TMR_W-1:0] SETUP_CYC    = TMR_W'((ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [TMR_W-1:0] PULSE_CYC    = TMR_W'((WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [TMR_W-1:0] HOLD_CYC     = TMR_W'((DATA_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [TMR_W-1:0] CS_HIGH_CYC  = TMR_W'((CS_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// ************************************************************
	// bus shape
	// ************************************************************
	localparam int DATA_W    = 16;
	localparam int DIE_BIT   = 26;
	localparam int PAGE_BITS = 4;

	// ************************************************************
	// controller states
	// ************************************************************
	typedef enum logic [3:0] {
		ST_RST_PULSE = 4'h0,
		ST_RST_WAIT  = 4'h1,
		ST_IDLE      = 4'h2,
		ST_RD_WAIT   = 4'h3,
		ST_WR_SETUP  = 4'h4,
		ST_WR_PULSE  = 4'h5,
		ST_WR_HOLD   = 4'h6,
		ST_RECOVER   = 4'h7
	} state_e;

endpackage

// *** shared/phase_timer_if.sv ***
// interface between the bus sequencer and its phase timer
`timescale 1ns/10ps
`default_nettype none
interface phase_timer_if;
	import nor_host_pkg::*;
	logic             load;
	logic [TMR_W-1:0] value;
	logic             done;

	modport ctrl  (output load, output value, input done);
	modport timer (input load, input value, output done);
endinterface
`default_nettype wire

// *** design/phase_timer.sv ***
// down counter that times each bus phase
`timescale 1ns/10ps
`default_nettype none
module phase_timer #(
	parameter logic [nor_host_pkg::TMR_W-1:0] RST_VAL = '0
) (
	input  wire logic  clk_i,
	input  wire logic  sys_rst_i,
	phase_timer_if.timer tmr
);
	import nor_host_pkg::*;

	logic [TMR_W-1:0] cnt_q;
	logic [TMR_W-1:0] cnt_d;

	// a load of n keeps done low for n-1 cycles after the load
	always_comb begin
		if (tmr.load) begin
			cnt_d = tmr.value - TMR_W'(1);
		end else if (cnt_q != '0) begin
			cnt_d = cnt_q - TMR_W'(1);
		end else begin
			cnt_d = '0;
		end
	end

	// register the count
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			cnt_q <= RST_VAL;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign tmr.done = (cnt_q == '0);
endmodule
`default_nettype wire

// *** design/nor_host.sv ***
// host side sequencer that drives a parallel nor flash over its pins
`timescale 1ns/10ps
`default_nettype none
module nor_host #(
	parameter int ADDR_W = 28
) (
	input  wire logic                              clk_i,
	input  wire logic                              sys_rst_i,
	input  wire logic                              req_valid_i,
	input  wire logic                              req_write_i,
	input  wire logic [ADDR_W-1:0]                 req_addr_i,
	input  wire logic [nor_host_pkg::DATA_W-1:0]   req_wdata_i,
	output logic                                   req_ready_o,
	output logic                                   rsp_valid_o,
	output logic [nor_host_pkg::DATA_W-1:0]        rsp_rdata_o,
	output logic                                   rsp_die_changed_o,
	input  wire logic                              byte_mode_i,
	input  wire logic                              wp_assert_i,
	input  wire logic                              vpp_high_i,
	input  wire logic                              flash_reset_req_i,
	output logic                                   busy_o,
	output logic                                   link_ready_o,
	output logic                                   chip_select_n_o,
	output logic                                   output_enable_n_o,
	output logic                                   write_strobe_n_o,
	output logic                                   width_select_n_o,
	output logic                                   reset_n_o,
	output logic                                   protect_vpp_n_o,
	output logic                                   vpp_high_req_o,
	output logic [ADDR_W-2:0]                      addr_o,
	output logic [14:0]                            dq_o,
	output logic                                   dq_lo_oe_o,
	output logic                                   dq_hi_oe_o,
	input  wire logic [14:0]                       dq_i,
	output logic                                   dq15_or_addr_lsb_o,
	output logic                                   dq15_or_addr_lsb_oe_o,
	input  wire logic                              dq15_or_addr_lsb_i,
	input  wire logic                              ready_busy_n_i
);
	import nor_host_pkg::*;

	// ************************************************************
	// state
	// ************************************************************
	state_e              state_q, state_d;
	logic                mode_q, mode_d;        // 1: eight-bit bus
	logic                page_q, page_d;        // read page left open
	logic                pend_q, pend_d;        // request held while a page closes
	logic                pend_wr_q, pend_wr_d;
	logic [ADDR_W-1:0]   pend_addr_q, pend_addr_d;
	logic [DATA_W-1:0]   pend_data_q, pend_data_d;
	logic                last_die_q, last_die_d;
	logic                ready_q, ready_d;
	logic                rsp_q, rsp_d;
	logic [DATA_W-1:0]   rdata_q, rdata_d;
	logic                diechg_q, diechg_d;
	logic                init_q, init_d;
	logic                cs_n_q, cs_n_d;
	logic                oe_n_q, oe_n_d;
	logic                we_n_q, we_n_d;
	logic                rst_n_q, rst_n_d;
	logic [ADDR_W-2:0]   addr_q, addr_d;
	logic [14:0]         dq_q, dq_d;
	logic                lo_oe_q, lo_oe_d;
	logic                hi_oe_q, hi_oe_d;
	logic                lsb_q, lsb_d;
	logic                lsb_oe_q, lsb_oe_d;
	logic                busy_q, prot_n_q, vpp_q;
	logic                wsel_n_q;              // width select pin, low for eight bits

	// current request and its pin mapping
	logic                take;
	logic                have;
	logic                cur_wr;
	logic [ADDR_W-1:0]   cur_addr;
	logic [DATA_W-1:0]   cur_data;
	logic [ADDR_W-2:0]   map_addr;
	logic                map_lsb;
	logic                hit;

	phase_timer_if tmr ();

	phase_timer #(
		.RST_VAL (RST_HOLD_CYC - TMR_W'(1))
	) u_timer (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.tmr       (tmr.timer)
	);

	// ************************************************************
	// request selection and address mapping
	// ************************************************************
	always_comb begin
		take     = req_ready_q_f();
		have     = pend_q || take;
		cur_wr   = pend_q ? pend_wr_q : req_write_i;
		cur_addr = pend_q ? pend_addr_q : req_addr_i;
		cur_data = pend_q ? pend_data_q : req_wdata_i;
		if (mode_q) begin
			map_addr = cur_addr[ADDR_W-1:1];
			map_lsb  = cur_addr[0];
		end else begin
			map_addr = cur_addr[ADDR_W-2:0];
			map_lsb  = cur_data[DATA_W-1];
		end
		hit = page_q && have && !cur_wr &&
		      (map_addr[ADDR_W-2:PAGE_BITS] == addr_q[ADDR_W-2:PAGE_BITS]);
	end

	function automatic logic req_ready_q_f();
		return ready_q && req_valid_i && !pend_q;
	endfunction

	// ************************************************************
	// sequencer next state
	// ************************************************************
	always_comb begin
		state_d     = state_q;
		mode_d      = mode_q;
		page_d      = page_q;
		pend_d      = pend_q;
		pend_wr_d   = pend_wr_q;
		pend_addr_d = pend_addr_q;
		pend_data_d = pend_data_q;
		last_die_d  = last_die_q;
		ready_d     = ready_q;
		rsp_d       = 1'b0;
		rdata_d     = rdata_q;
		diechg_d    = diechg_q;
		init_d      = init_q;
		cs_n_d      = cs_n_q;
		oe_n_d      = oe_n_q;
		we_n_d      = we_n_q;
		rst_n_d     = rst_n_q;
		addr_d      = addr_q;
		dq_d        = dq_q;
		lo_oe_d     = lo_oe_q;
		hi_oe_d     = hi_oe_q;
		lsb_d       = lsb_q;
		lsb_oe_d    = lsb_oe_q;
		tmr.load    = 1'b0;
		tmr.value   = '0;
		case (state_q)
			ST_RST_PULSE: begin
				if (tmr.done) begin
					rst_n_d   = 1'b1;
					tmr.load  = 1'b1;
					tmr.value = WAKE_CYC;
					state_d   = ST_RST_WAIT;
				end
			end
			ST_RST_WAIT: begin
				if (tmr.done) begin
					init_d  = 1'b1;
					ready_d = 1'b1;
					state_d = ST_IDLE;
				end
			end
			ST_IDLE: begin
				if (take) begin
					ready_d = 1'b0;
				end
				if (page_q && !hit) begin
					// close the page before any other access
					cs_n_d    = 1'b1;
					ready_d   = 1'b0;                               // recovery takes no request
					oe_n_d    = 1'b1;
					page_d    = 1'b0;
					tmr.load  = 1'b1;
					tmr.value = CS_HIGH_CYC;
					state_d   = ST_RECOVER;
					if (take) begin
						pend_d      = 1'b1;
						pend_wr_d   = req_write_i;
						pend_addr_d = req_addr_i;
						pend_data_d = req_wdata_i;
					end
				end else if (have) begin
					pend_d     = 1'b0;
					addr_d     = map_addr;
					diechg_d   = map_addr[DIE_BIT] != last_die_q;
					last_die_d = map_addr[DIE_BIT];
					cs_n_d     = 1'b0;
					tmr.load   = 1'b1;
					if (cur_wr) begin
						oe_n_d    = 1'b1;
						dq_d      = cur_data[14:0];
						lo_oe_d   = 1'b1;
						hi_oe_d   = !mode_q;
						lsb_d     = map_lsb;
						lsb_oe_d  = 1'b1;
						tmr.value = SETUP_CYC;
						state_d   = ST_WR_SETUP;
					end else begin
						oe_n_d    = 1'b0;
						we_n_d    = 1'b1;
						lo_oe_d   = 1'b0;
						hi_oe_d   = 1'b0;
						lsb_d     = map_lsb;
						lsb_oe_d  = mode_q;
						tmr.value = hit ? PAGE_CYC : ACCESS_CYC;
						state_d   = ST_RD_WAIT;
					end
				end
			end
			ST_RD_WAIT: begin
				if (tmr.done) begin
					if (mode_q) begin
						rdata_d = {8'h00, dq_i[7:0]};
					end else begin
						rdata_d = {dq15_or_addr_lsb_i, dq_i};
					end
					rsp_d   = 1'b1;
					page_d  = 1'b1;
					ready_d = 1'b1;
					state_d = ST_IDLE;
				end
			end
			ST_WR_SETUP: begin
				if (tmr.done) begin
					we_n_d    = 1'b0;
					tmr.load  = 1'b1;
					tmr.value = PULSE_CYC;
					state_d   = ST_WR_PULSE;
				end
			end
			ST_WR_PULSE: begin
				if (tmr.done) begin
					we_n_d    = 1'b1;
					tmr.load  = 1'b1;
					tmr.value = HOLD_CYC;
					state_d   = ST_WR_HOLD;
				end
			end
			ST_WR_HOLD: begin
				if (tmr.done) begin
					cs_n_d    = 1'b1;
					lo_oe_d   = 1'b0;
					hi_oe_d   = 1'b0;
					lsb_oe_d  = mode_q;
					rsp_d     = 1'b1;
					tmr.load  = 1'b1;
					tmr.value = CS_HIGH_CYC;
					state_d   = ST_RECOVER;
				end
			end
			ST_RECOVER: begin
				if (tmr.done) begin
					mode_d   = byte_mode_i;
					lsb_oe_d = byte_mode_i;
					ready_d  = !pend_q;
					state_d  = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_RST_PULSE;
			end
		endcase
		// a reset request aborts whatever runs on the bus
		if (flash_reset_req_i && state_q != ST_RST_PULSE) begin
			state_d   = ST_RST_PULSE;
			rst_n_d   = 1'b0;
			cs_n_d    = 1'b1;
			oe_n_d    = 1'b1;
			we_n_d    = 1'b1;
			lo_oe_d   = 1'b0;
			hi_oe_d   = 1'b0;
			lsb_oe_d  = mode_d;
			page_d    = 1'b0;
			pend_d    = 1'b0;
			ready_d   = 1'b0;
			rsp_d     = 1'b0;
			init_d    = 1'b0;
			tmr.load  = 1'b1;
			tmr.value = RST_HOLD_CYC;
		end
	end

	// ************************************************************
	// sequencer registers
	// ************************************************************
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			state_q     <= ST_RST_PULSE;
			mode_q      <= 1'b0;
			page_q      <= 1'b0;
			pend_q      <= 1'b0;
			pend_wr_q   <= 1'b0;
			pend_addr_q <= '0;
			pend_data_q <= '0;
			last_die_q  <= 1'b0;
			ready_q     <= 1'b0;
			rsp_q       <= 1'b0;
			rdata_q     <= '0;
			diechg_q    <= 1'b0;
			init_q      <= 1'b0;
			cs_n_q      <= 1'b1;
			oe_n_q      <= 1'b1;
			we_n_q      <= 1'b1;
			rst_n_q     <= 1'b0;
			addr_q      <= '0;
			dq_q        <= '0;
			lo_oe_q     <= 1'b0;
			hi_oe_q     <= 1'b0;
			lsb_q       <= 1'b0;
			lsb_oe_q    <= 1'b0;
			wsel_n_q    <= 1'b1;
		end else begin
			state_q     <= state_d;
			mode_q      <= mode_d;
			page_q      <= page_d;
			pend_q      <= pend_d;
			pend_wr_q   <= pend_wr_d;
			pend_addr_q <= pend_addr_d;
			pend_data_q <= pend_data_d;
			last_die_q  <= last_die_d;
			ready_q     <= ready_d;
			rsp_q       <= rsp_d;
			rdata_q     <= rdata_d;
			diechg_q    <= diechg_d;
			init_q      <= init_d;
			cs_n_q      <= cs_n_d;
			oe_n_q      <= oe_n_d;
			we_n_q      <= we_n_d;
			rst_n_q     <= rst_n_d;
			addr_q      <= addr_d;
			dq_q        <= dq_d;
			lo_oe_q     <= lo_oe_d;
			hi_oe_q     <= hi_oe_d;
			lsb_q       <= lsb_d;
			lsb_oe_q    <= lsb_oe_d;
			wsel_n_q    <= !mode_d;
		end
	end

	// ************************************************************
	// protection and status pins
	// ************************************************************
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			busy_q   <= 1'b0;
			prot_n_q <= 1'b0;
			vpp_q    <= 1'b0;
		end else begin
			busy_q   <= !ready_busy_n_i;
			prot_n_q <= !wp_assert_i;
			vpp_q    <= vpp_high_i && !wp_assert_i;
		end
	end

	assign req_ready_o           = ready_q;
	assign rsp_valid_o           = rsp_q;
	assign rsp_rdata_o           = rdata_q;
	assign rsp_die_changed_o     = diechg_q;
	assign busy_o                = busy_q;
	assign link_ready_o          = init_q;
	assign chip_select_n_o       = cs_n_q;
	assign output_enable_n_o     = oe_n_q;
	assign write_strobe_n_o      = we_n_q;
	assign width_select_n_o      = wsel_n_q;                    // driven always, never floating
	assign reset_n_o             = rst_n_q;
	assign protect_vpp_n_o       = prot_n_q;
	assign vpp_high_req_o        = vpp_q;
	assign addr_o                = addr_q;
	assign dq_o                  = dq_q;
	assign dq_lo_oe_o            = lo_oe_q;
	assign dq_hi_oe_o            = hi_oe_q;
	assign dq15_or_addr_lsb_o    = lsb_q;
	assign dq15_or_addr_lsb_oe_o = lsb_oe_q;
endmodule
`default_nettype wire

// *** sim/nor_flash_model.sv ***
// behavioural parallel nor flash: array, page timing, write latch and ready busy
`timescale 1ns/10ps
`default_nettype none
module nor_flash_model #(
	parameter int ACC_NS  = 100,
	parameter int PAGE_NS = 25
) (
	input  wire logic        ce_n_i,
	input  wire logic        oe_n_i,
	input  wire logic        we_n_i,
	input  wire logic        rst_n_i,
	input  wire logic        byte_n_i,
	input  wire logic [26:0] addr_i,
	input  wire logic [15:0] dq_i,
	input  wire logic [15:0] op_ns_i,
	output logic      [15:0] dq_o,
	output logic             dq_lo_oe_o,
	output logic             dq_hi_oe_o,
	output logic             ready_busy_n_o
);
	logic [7:0]  mem [logic [27:0]];
	logic [27:0] key, wr_key;
	logic [24:0] far, far_d;
	logic [4:0]  near, near_d;
	logic [15:0] word;
	logic        busy = 1'b0;
	int          wcnt = 0;
	// ********************
	// read path
	// ********************
	function automatic logic [7:0] rd(input logic [27:0] k);
		return mem.exists(k) ? mem[k] : 8'hff;
	endfunction
	// byte key: x16 words fill two bytes, x8 uses the shared pin as lowest bit
	assign key  = byte_n_i ? {addr_i, 1'b0} : {addr_i, dq_i[15]};
	assign far  = {addr_i[26:4], ce_n_i, oe_n_i};
	assign near = {addr_i[3:0], key[0]};
	assign #(ACC_NS) far_d = far;
	assign #(PAGE_NS) near_d = near;
	always @(key or byte_n_i or wcnt) begin
		word = byte_n_i ? {rd(key | 28'h1), rd(key)} : {8'h00, rd(key)};
	end
	// until settled the lines carry the inverse, so early sampling shows up
	assign dq_o = (far_d === far && near_d === near) ? word : ~word;
	assign dq_lo_oe_o = !ce_n_i && !oe_n_i && we_n_i && rst_n_i;
	assign dq_hi_oe_o = dq_lo_oe_o && byte_n_i;
	// ********************
	// write latch and busy
	// ********************
	always @(negedge we_n_i) begin
		if (!ce_n_i && rst_n_i)
			wr_key = key;
	end
	always @(posedge we_n_i) begin
		if (!ce_n_i && rst_n_i) begin
			mem[wr_key] = dq_i[7:0];
			if (byte_n_i)
				mem[wr_key | 28'h1] = dq_i[15:8];
			wcnt++;
			busy = 1'b1;
			busy <= #(op_ns_i) 1'b0;
		end
	end
	// reset aborts the running operation and returns to array read
	always @(negedge rst_n_i) begin
		busy = 1'b0;
	end
	assign ready_busy_n_o = !busy;
endmodule
`default_nettype wire

// *** sim/nor_host_properties.sv ***
// pin level checks of the nor flash host controller
`timescale 1ns/10ps
`default_nettype none
module nor_host_properties #(
	parameter int ADDR_W = 28
) (
	input wire logic              clk_i,
	input wire logic              sys_rst_i,
	input wire logic              req_ready_o,
	input wire logic              wp_assert_i,
	input wire logic              busy_o,
	input wire logic              chip_select_n_o,
	input wire logic              output_enable_n_o,
	input wire logic              write_strobe_n_o,
	input wire logic              width_select_n_o,
	input wire logic              reset_n_o,
	input wire logic              protect_vpp_n_o,
	input wire logic              vpp_high_req_o,
	input wire logic [ADDR_W-2:0] addr_o,
	input wire logic [14:0]       dq_o,
	input wire logic              dq_lo_oe_o,
	input wire logic              dq_hi_oe_o,
	input wire logic              dq15_or_addr_lsb_oe_o,
	input wire logic              ready_busy_n_i
);
	import nor_host_pkg::*;
	logic [TMR_W-1:0] low_q, low_d, high_q, high_d;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	// ********************
	// cycles the flash reset pin spent low and high
	// ********************
	always_comb begin
		low_d  = low_q;
		high_d = high_q;
		if (sys_rst_i || reset_n_o)
			low_d = '0;
		else if (low_q != '1)
			low_d = low_q + 1'b1;
		if (sys_rst_i || !reset_n_o)
			high_d = '0;
		else if (high_q != '1)
			high_d = high_q + 1'b1;
	end
	always_ff @(posedge clk_i) begin
		low_q  <= low_d;
		high_q <= high_d;
	end
	a_reset_long: assert property ($rose(reset_n_o) |-> low_q >= RST_HOLD_CYC - 8'h01)
		else $error("flash reset pulse too short");
	a_wake_wait: assert property (req_ready_o |-> reset_n_o && high_q >= WAKE_CYC - 8'h01)
		else $error("request taken before wake-up time");
	a_reset_quiet: assert property (!reset_n_o |-> !req_ready_o)
		else $error("request port open while flash held in reset");
	a_write_oe_high: assert property (!write_strobe_n_o |-> output_enable_n_o && !chip_select_n_o && dq_lo_oe_o)
		else $error("write strobe low without select, data or with output enable");
	a_addr_setup: assert property ($fell(write_strobe_n_o) |-> !$past(chip_select_n_o) && $stable(addr_o))
		else $error("address or select not set up before strobe fall");
	a_data_hold: assert property ($rose(write_strobe_n_o) |-> dq_lo_oe_o && $stable(dq_o[7:0]))
		else $error("write data not held around strobe rise");
	a_width_steady: assert property (!write_strobe_n_o |=> $stable(width_select_n_o))
		else $error("width select moved during a write");
	a_read_no_fight: assert property (!output_enable_n_o |-> write_strobe_n_o && !dq_lo_oe_o && !dq_hi_oe_o)
		else $error("host drives data or strobes during a read");
	a_cs_gap: assert property ($rose(chip_select_n_o) |-> chip_select_n_o [*2])
		else $error("chip select high too short between accesses");
	a_byte_pins: assert property (!width_select_n_o |-> !dq_hi_oe_o && dq15_or_addr_lsb_oe_o)
		else $error("byte mode pin directions wrong");
	a_busy_mirror: assert property (!$past(sys_rst_i) |-> busy_o == !$past(ready_busy_n_i))
		else $error("busy flag does not follow ready busy pin");
	a_protect_follow: assert property (!$past(sys_rst_i) |-> protect_vpp_n_o == !$past(wp_assert_i))
		else $error("protect pin does not follow request");
	a_vpp_guard: assert property (vpp_high_req_o |-> protect_vpp_n_o)
		else $error("high voltage asked while protecting");
endmodule
bind nor_host nor_host_properties #(.ADDR_W(ADDR_W)) nor_host_properties_inst (
	.clk_i, .sys_rst_i, .req_ready_o, .wp_assert_i, .busy_o, .chip_select_n_o, .output_enable_n_o,
	.write_strobe_n_o, .width_select_n_o, .reset_n_o, .protect_vpp_n_o, .vpp_high_req_o, .addr_o,
	.dq_o, .dq_lo_oe_o, .dq_hi_oe_o, .dq15_or_addr_lsb_oe_o, .ready_busy_n_i
);
`default_nettype wire

// *** sim/test_nor_host.sv ***
// self-checking bench: host controller against a flash model and a byte map
`timescale 1ns/10ps
`default_nettype none
module test_nor_host;
	import nor_host_pkg::*;
	logic        clk_i, sys_rst_i, req_valid_i, req_write_i, byte_mode_i, wp_assert_i, vpp_high_i;
	logic        flash_reset_req_i, dq15_or_addr_lsb_i, ready_busy_n_i, req_ready_o, rsp_valid_o;
	logic        rsp_die_changed_o, busy_o, link_ready_o, chip_select_n_o, output_enable_n_o;
	logic        write_strobe_n_o, width_select_n_o, reset_n_o, protect_vpp_n_o, vpp_high_req_o;
	logic        dq_lo_oe_o, dq_hi_oe_o, dq15_or_addr_lsb_o, dq15_or_addr_lsb_oe_o, m_lo, m_hi;
	logic [27:0] req_addr_i;
	logic [26:0] addr_o;
	logic [15:0] req_wdata_i, rsp_rdata_o, mdq, bus, op_ns;
	logic [15:0] flt = 16'h5a3c;
	logic [14:0] dq_o, dq_i;
	logic [7:0]  bm [logic [27:0]];
	logic [31:0] rs = 32'h73bb7100;
	logic        x8, have_prev, die;
	int          num_errors = 0;
	int          n_tests = 0;
	// ********************
	// wiring: undriven lines show a pattern that moves every cycle
	// ********************
	always @(posedge clk_i) flt <= {flt[14:0], ~flt[15]};
	assign bus[7:0]  = dq_lo_oe_o ? dq_o[7:0] : m_lo ? mdq[7:0] : flt[7:0];
	assign bus[14:8] = dq_hi_oe_o ? dq_o[14:8] : m_hi ? mdq[14:8] : flt[14:8];
	assign bus[15]   = dq15_or_addr_lsb_oe_o ? dq15_or_addr_lsb_o : m_hi ? mdq[15] : flt[15];
	assign dq_i = bus[14:0];
	assign dq15_or_addr_lsb_i = bus[15];
	nor_host #(.ADDR_W(28)) nor_host_inst (
		.clk_i, .sys_rst_i, .req_valid_i, .req_write_i, .req_addr_i, .req_wdata_i, .req_ready_o,
		.rsp_valid_o, .rsp_rdata_o, .rsp_die_changed_o, .byte_mode_i, .wp_assert_i, .vpp_high_i,
		.flash_reset_req_i, .busy_o, .link_ready_o, .chip_select_n_o, .output_enable_n_o,
		.write_strobe_n_o, .width_select_n_o, .reset_n_o, .protect_vpp_n_o, .vpp_high_req_o,
		.addr_o, .dq_o, .dq_lo_oe_o, .dq_hi_oe_o, .dq_i, .dq15_or_addr_lsb_o,
		.dq15_or_addr_lsb_oe_o, .dq15_or_addr_lsb_i, .ready_busy_n_i
	);
	nor_flash_model nor_flash_model_inst (
		.ce_n_i(chip_select_n_o), .oe_n_i(output_enable_n_o), .we_n_i(write_strobe_n_o),
		.rst_n_i(reset_n_o), .byte_n_i(width_select_n_o), .addr_i(addr_o), .dq_i(bus),
		.op_ns_i(op_ns), .dq_o(mdq), .dq_lo_oe_o(m_lo), .dq_hi_oe_o(m_hi),
		.ready_busy_n_o(ready_busy_n_i)
	);
	// ********************
	// helpers
	// ********************
	function automatic logic [31:0] rnd();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction
	function automatic logic [7:0] rb(input logic [27:0] k);
		return bm.exists(k) ? bm[k] : 8'hff;
	endfunction
	// random address in the current width with the die bit given
	function automatic logic [27:0] raddr(input logic hi);
		logic [31:0] r;
		r = rnd();
		return x8 ? {hi, r[26:0]} : {1'b0, hi, r[25:0]};
	endfunction
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		$display("comparisons %0d, mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic wait_ready();
		int n;
		n = 0;
		while (req_ready_o !== 1'b1 && n < 200) begin
			@(negedge clk_i);
			n++;
		end
		chk({15'h0, req_ready_o}, 16'h1);
	endtask
	// one request, compared with the byte map when it answers
	task automatic access(input logic wr, input logic [27:0] a, input logic [15:0] d);
		logic [27:0] k;
		int n;
		k = x8 ? a : {a[26:0], 1'b0};
		wait_ready();
		req_valid_i = 1'b1;
		req_write_i = wr;
		req_addr_i = a;
		req_wdata_i = d;
		@(negedge clk_i);
		req_valid_i = 1'b0;
		req_wdata_i = 16'(rnd());
		n = 0;
		while (rsp_valid_o !== 1'b1 && n < 40) begin
			@(negedge clk_i);
			n++;
		end
		chk({15'h0, rsp_valid_o}, 16'h1);
		if (wr) begin
			bm[k] = d[7:0];
			if (!x8)
				bm[k | 28'h1] = d[15:8];
		end else
			chk(rsp_rdata_o, x8 ? {8'h00, rb(k)} : {rb(k | 28'h1), rb(k)});
		if (have_prev)
			chk({15'h0, rsp_die_changed_o}, {15'h0, die != k[27]});
		die = k[27];
		have_prev = 1'b1;
	endtask
	// write, read back, then a page neighbour on alternating dies
	task automatic rw_round(input int n);
		logic [27:0] a;
		for (int i = 0; i < n; i++) begin
			a = raddr(i[0]);
			access(1'b1, a, 16'(rnd()));
			access(1'b0, a, 16'h0000);
			access(1'b0, a ^ 28'h1, 16'h0000);
		end
	endtask
	task automatic sys_reset();
		sys_rst_i = 1'b1;
		repeat (6) @(negedge clk_i);
		sys_rst_i = 1'b0;
		have_prev = 1'b0;
		wait_ready();
		chk({15'h0, link_ready_o}, 16'h1);
	endtask
	// ********************
	// clock, watchdog and main sequence
	// ********************
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	initial begin
		#200us;
		num_errors++;
		finish_test();
	end
	initial begin
		{req_valid_i, req_write_i, byte_mode_i, wp_assert_i, vpp_high_i, flash_reset_req_i} = '0;
		req_addr_i = '0;
		req_wdata_i = '0;
		op_ns = 16'd400;
		x8 = 1'b0;
		die = 1'b0;
		sys_reset();
		for (int i = 0; i < 4; i++)
			access(1'b0, raddr(i[0]), 16'h0000);
		$display("erased reads done");
		rw_round(6);
		access(1'b1, raddr(1'b0), 16'(rnd()));
		@(negedge clk_i);
		chk({15'h0, busy_o}, 16'h1);
		repeat (25) @(negedge clk_i);
		chk({15'h0, busy_o}, 16'h0);
		$display("word program and busy done");
		for (int i = 0; i < 4; i++) begin
			{vpp_high_i, wp_assert_i} = 2'(i);
			repeat (3) @(negedge clk_i);
			chk({15'h0, protect_vpp_n_o}, {15'h0, !wp_assert_i});
			chk({15'h0, vpp_high_req_o}, {15'h0, vpp_high_i && !wp_assert_i});
		end
		$display("protect pins done");
		op_ns = 16'd3000;
		access(1'b1, raddr(1'b1), 16'(rnd()));
		flash_reset_req_i = 1'b1;
		@(negedge clk_i);
		flash_reset_req_i = 1'b0;
		repeat (5) @(negedge clk_i);
		chk({15'h0, busy_o}, 16'h0);
		chk({15'h0, reset_n_o}, 16'h0);
		chk({15'h0, link_ready_o}, 16'h0);
		have_prev = 1'b0;
		op_ns = 16'd60;
		rw_round(2);
		$display("abort by reset done");
		access(1'b1, raddr(1'b0), 16'(rnd()));
		byte_mode_i = 1'b1;
		x8 = 1'b1;
		wait_ready();
		chk({15'h0, width_select_n_o}, 16'h0);
		rw_round(6);
		$display("byte mode done");
		byte_mode_i = 1'b0;
		x8 = 1'b0;
		sys_reset();
		chk({15'h0, width_select_n_o}, 16'h1);
		rw_round(2);
		$display("second reset done");
		finish_test();
	end
endmodule
`default_nettype wire
